// ===== rtl/host_port_pkg.sv
// Purpose: shared constants and carriers for the two-channel host port
// Assumes: 8-bit host bus, slave strobes are one-cycle pulses on clock_in
// Notes:   slave register indices select the buffers and status registers
package host_port_pkg;
  localparam int          DATA_W       = 8;
  localparam int          FIFO_DEPTH   = 4;
  localparam int          SLV_ADDR_W   = 3;
  // slave-side register indices
  localparam logic [2:0]  SLV_CH1_IN   = 3'h0;
  localparam logic [2:0]  SLV_CH1_OUT  = 3'h1;
  localparam logic [2:0]  SLV_CH1_STAT = 3'h2;
  localparam logic [2:0]  SLV_CH2_IN   = 3'h3;
  localparam logic [2:0]  SLV_CH2_OUT  = 3'h4;
  localparam logic [2:0]  SLV_CH2_STAT = 3'h5;
  // status field layout
  localparam int          ST_CMD_BIT   = 3;
  localparam int          ST_IBF_BIT   = 1;
  localparam int          ST_OBF_BIT   = 0;
  localparam logic [7:0]  ST_USER_MASK = 8'hf4;
  localparam logic [7:0]  ST_RESET     = 8'h00;
  localparam logic [7:0]  UNMAPPED_RD  = 8'h00;
  localparam logic [7:0]  HOST_IDLE    = 8'h00;
  // fast gate command codes and data bit
  localparam logic [7:0]  CMD_GATE     = 8'hd1;
  localparam logic [7:0]  CMD_NULL     = 8'hff;
  localparam int          GATE_BIT     = 1;
  localparam logic        GATE_RESET   = 1'b1;
  localparam logic [1:0]  SYNC_IDLE    = 2'h3;

  // one host write, captured at the strobe's rising edge
  typedef struct packed {
    logic              chan2;
    logic              addr;
    logic [7:0]        data;
  } host_event_t;

  typedef struct packed {
    logic [1:0]        sel1_sync;
    logic [1:0]        sel2_sync;
    logic [1:0]        rd_sync;
    logic [1:0]        wr_sync;
    logic [1:0]        addr_sync;
    logic [1:0]        stby_sync;
    logic [1:0][7:0]   data_sync;
    logic              rd_prev;
    logic              wr_prev;
    logic              wr_cap_valid;
    host_event_t       wr_cap;
    logic              pend_valid;
    host_event_t       pend;
    logic              rd_tgt1;
    logic              rd_tgt2;
    logic [7:0]        chan1_host_in_buffer;
    logic [7:0]        chan1_host_out_buffer;
    logic [7:0]        chan1_status;
    logic [7:0]        chan2_host_in_buffer;
    logic [7:0]        chan2_host_out_buffer;
    logic [7:0]        chan2_status;
    logic              gate_armed;
    logic              gate_out;
    logic              fge_prev;
    logic [7:0]        host_dout;
    logic              host_oe_n;
    logic [7:0]        slave_rdata;
  } hp_state_t;
endpackage

// ===== rtl/host_port_channel_status_regs.sv
// Purpose: host port buffers, status flags and fast gate decode
// Assumes: host pins are asynchronous; slave strobes are single-cycle pulses
// Notes:   host writes queue through a small fifo before touching the flags
//
// Functional notes
// - user status bits slave writable, host read-only
// - channel-1 status clears on reset and standby
// - command, input-full, output-full bits not writable
// - slave zero clears output-full, one ignored
// - channel-1 host write copies address bit
// - channel-1 host write sets input-full
// - channel-1 slave input read clears input-full
// - input-full flags drive slave interrupt requests
// - channel-1 slave output write sets output-full
// - channel-1 host output read clears output-full
// - fast gate mode alters input-full behaviour
// - channel-2 input: host writes, slave reads
// - channel-2 host write latches data and address
// - buffers have no defined reset value
// - channel-2 output: slave read-write, host reads
// - channel-2 output drives host bus on read
// - channel-2 status clears on reset and standby
// - channel-2 command flag follows address bit
// - channel-2 host write sets input-full
// - channel-2 slave input read clears input-full
// - channel-2 slave output write sets output-full
// - channel-2 output-full cleared by host read, slave zero
// - address high reads status, low reads output
// - fast gate decodes d1 then drives data bit
`timescale 1ns/100ps

// small fifo; the drain side may stall so the queue really fills
module hp_event_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input  wire logic             clock_in,
  input  wire logic             sys_rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int PTR_W = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [PTR_W:0]              count;
  } fifo_state_t;
  fifo_state_t st_reg;
  fifo_state_t st_next;
  logic        push;
  logic        pop;
  // handshakes come straight from the count
  assign in_ready_out  = st_reg.count != (PTR_W+1)'(DEPTH);
  assign out_valid_out = st_reg.count != '0;
  assign out_data_out  = st_reg.mem[st_reg.rd_ptr];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = in_data_in;
      st_next.wr_ptr             = st_reg.wr_ptr + 1'b1;
    end
    st_next.rd_ptr = st_reg.rd_ptr + PTR_W'(pop);
    st_next.count = st_reg.count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    // storage keeps its contents; pointers and count restart
    if (sys_rst_in) begin
      st_next.wr_ptr = '0;
      st_next.rd_ptr = '0;
      st_next.count  = '0;
    end
  end
  always_ff @(posedge clock_in) begin
    st_reg <= st_next;
  end
endmodule

module host_port_channel_status_regs (
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  input  wire logic       hw_standby_n_in,
  input  wire logic       chan1_select_n_in,
  input  wire logic       chan2_select_n_in,
  input  wire logic       host_read_strobe_n_in,
  input  wire logic       host_write_strobe_n_in,
  input  wire logic       host_addr_bit_in,
  input  wire logic [7:0] host_data_in,
  output logic      [7:0] host_data_out,
  output logic            host_data_oe_n_out,
  output logic            host_wr_ready_out,
  input  wire logic       fast_gate_enable_in,
  input  wire logic [2:0] slave_addr_in,
  input  wire logic       slave_rd_in,
  input  wire logic       slave_wr_in,
  input  wire logic [7:0] slave_wdata_in,
  output logic      [7:0] slave_rdata_out,
  output logic            chan1_in_full_irq_out,
  output logic            chan2_in_full_irq_out,
  output logic            gate_a20_out
);
  host_port_pkg::hp_state_t   s;
  host_port_pkg::hp_state_t   n;
  host_port_pkg::host_event_t ev;
  logic                       fifo_in_ready;
  logic                       fifo_out_valid;
  logic                       fifo_out_ready;
  logic                       pop;
  logic                       sel1;
  logic                       sel2;
  logic                       haddr;
  logic                       wr_rise;
  logic                       rd_rise;
  logic                       slv_in_rd;
  // pin levels only from the second synchroniser stage
  assign sel1    = !s.sel1_sync[1];
  assign sel2    = !s.sel2_sync[1];
  assign haddr   = s.addr_sync[1];
  assign wr_rise = s.wr_sync[1] && !s.wr_prev;
  assign rd_rise = s.rd_sync[1] && !s.rd_prev;
  // a slave read of an input buffer stalls the drain, so the read's clear
  // and a queued write's set never meet in one cycle
  assign slv_in_rd = slave_rd_in &&
                     (slave_addr_in == host_port_pkg::SLV_CH1_IN ||
                      slave_addr_in == host_port_pkg::SLV_CH2_IN);
  assign fifo_out_ready = !slv_in_rd;
  assign pop            = fifo_out_valid && fifo_out_ready;
  hp_event_fifo #(
    .WIDTH ($bits(host_port_pkg::host_event_t)),
    .DEPTH (host_port_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock_in      (clock_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (s.pend_valid),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (s.pend),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_out_ready),
    .out_data_out  (ev)
  );
  // outputs straight from state flops
  assign host_data_out         = s.host_dout;
  assign host_data_oe_n_out    = s.host_oe_n;
  assign host_wr_ready_out     = !s.pend_valid;
  assign slave_rdata_out       = s.slave_rdata;
  assign chan1_in_full_irq_out = s.chan1_status[host_port_pkg::ST_IBF_BIT];
  assign chan2_in_full_irq_out = s.chan2_status[host_port_pkg::ST_IBF_BIT];
  assign gate_a20_out          = s.gate_out;
  always_comb begin
    logic special;
    special = 1'b0;
    n = s;
    // two-stage synchronisers for every host pin
    n.sel1_sync = {s.sel1_sync[0], chan1_select_n_in};
    n.sel2_sync = {s.sel2_sync[0], chan2_select_n_in};
    n.rd_sync   = {s.rd_sync[0], host_read_strobe_n_in};
    n.wr_sync   = {s.wr_sync[0], host_write_strobe_n_in};
    n.addr_sync = {s.addr_sync[0], host_addr_bit_in};
    n.stby_sync = {s.stby_sync[0], hw_standby_n_in};
    n.data_sync = {s.data_sync[0], host_data_in};
    n.rd_prev   = s.rd_sync[1];
    n.wr_prev   = s.wr_sync[1];
    // capture the write while the strobe is low; it lands at the rising edge
    if (!s.wr_sync[1] && (sel1 || sel2)) begin
      n.wr_cap_valid = 1'b1;
      n.wr_cap.chan2 = !sel1;
      n.wr_cap.addr  = haddr;
      n.wr_cap.data  = s.data_sync[1];
    end
    if (s.pend_valid && fifo_in_ready) begin
      n.pend_valid = 1'b0;
    end
    if (wr_rise) begin
      n.wr_cap_valid = 1'b0;
      if (s.wr_cap_valid) begin
        n.pend_valid = 1'b1;
        n.pend       = s.wr_cap;
      end
    end
    // host read: status when address high, output buffer when low
    if (!s.rd_sync[1] && (sel1 || sel2)) begin
      n.host_oe_n = 1'b0;
      n.rd_tgt1   = sel1 && !haddr;
      n.rd_tgt2   = !sel1 && !haddr;
      if (sel1) begin
        n.host_dout = haddr ? s.chan1_status : s.chan1_host_out_buffer;
      end else begin
        n.host_dout = haddr ? s.chan2_status : s.chan2_host_out_buffer;
      end
    end else begin
      n.host_oe_n = 1'b1;
      n.host_dout = host_port_pkg::HOST_IDLE;
    end
    // output-full clears when the read strobe rises
    if (rd_rise) begin
      if (s.rd_tgt1) begin
        n.chan1_status[host_port_pkg::ST_OBF_BIT] = 1'b0;
      end
      if (s.rd_tgt2) begin
        n.chan2_status[host_port_pkg::ST_OBF_BIT] = 1'b0;
      end
      n.rd_tgt1 = 1'b0;
      n.rd_tgt2 = 1'b0;
    end
    // slave reads answer one cycle later; input reads clear input-full
    if (slave_rd_in) begin
      unique case (slave_addr_in)
        host_port_pkg::SLV_CH1_IN: begin
          n.slave_rdata = s.chan1_host_in_buffer;
          n.chan1_status[host_port_pkg::ST_IBF_BIT] = 1'b0;
        end
        host_port_pkg::SLV_CH1_OUT:  n.slave_rdata = s.chan1_host_out_buffer;
        host_port_pkg::SLV_CH1_STAT: n.slave_rdata = s.chan1_status;
        host_port_pkg::SLV_CH2_IN: begin
          n.slave_rdata = s.chan2_host_in_buffer;
          n.chan2_status[host_port_pkg::ST_IBF_BIT] = 1'b0;
        end
        host_port_pkg::SLV_CH2_OUT:  n.slave_rdata = s.chan2_host_out_buffer;
        host_port_pkg::SLV_CH2_STAT: n.slave_rdata = s.chan2_status;
        default:                     n.slave_rdata = host_port_pkg::UNMAPPED_RD;
      endcase
    end
    // slave writes; the set of output-full follows the host clear so it wins
    if (slave_wr_in) begin
      unique case (slave_addr_in)
        host_port_pkg::SLV_CH1_OUT: begin
          n.chan1_host_out_buffer = slave_wdata_in;
          n.chan1_status[host_port_pkg::ST_OBF_BIT] = 1'b1;
        end
        host_port_pkg::SLV_CH2_OUT: begin
          n.chan2_host_out_buffer = slave_wdata_in;
          n.chan2_status[host_port_pkg::ST_OBF_BIT] = 1'b1;
        end
        host_port_pkg::SLV_CH1_STAT: begin
          // user bits change and a zero clears output-full; a same-cycle flag clear is kept
          n.chan1_status = (n.chan1_status & ~host_port_pkg::ST_USER_MASK) |
                           (slave_wdata_in & host_port_pkg::ST_USER_MASK);
          if (!slave_wdata_in[host_port_pkg::ST_OBF_BIT]) begin
            n.chan1_status[host_port_pkg::ST_OBF_BIT] = 1'b0;
          end
        end
        host_port_pkg::SLV_CH2_STAT: begin
          n.chan2_status = (n.chan2_status & ~host_port_pkg::ST_USER_MASK) |
                           (slave_wdata_in & host_port_pkg::ST_USER_MASK);
          if (!slave_wdata_in[host_port_pkg::ST_OBF_BIT]) begin
            n.chan2_status[host_port_pkg::ST_OBF_BIT] = 1'b0;
          end
        end
        default: ; // input buffers and holes ignore writes; a same-cycle read stands
      endcase
    end
    // queued host write takes effect; standby and reset still override its input-full set
    if (pop) begin
      if (ev.chan2) begin
        n.chan2_host_in_buffer = ev.data;
        n.chan2_status[host_port_pkg::ST_CMD_BIT] = ev.addr;
        n.chan2_status[host_port_pkg::ST_IBF_BIT] = 1'b1;
      end else begin
        // fast gate: d1 arms, next data drives the gate, no firmware wake
        if (fast_gate_enable_in) begin
          if (ev.addr && ev.data == host_port_pkg::CMD_GATE) begin
            n.gate_armed = 1'b1;
            special      = 1'b1;
          end else if (!ev.addr && s.gate_armed) begin
            n.gate_out   = ev.data[host_port_pkg::GATE_BIT];
            n.gate_armed = 1'b0;
            special      = 1'b1;
          end else if (ev.addr && ev.data == host_port_pkg::CMD_NULL) begin
            n.gate_armed = 1'b0;
            special      = 1'b1;
          end else begin
            n.gate_armed = 1'b0;
          end
        end
        n.chan1_host_in_buffer = ev.data;
        n.chan1_status[host_port_pkg::ST_CMD_BIT] = ev.addr;
        if (!special) begin
          n.chan1_status[host_port_pkg::ST_IBF_BIT] = 1'b1;
        end
      end
    end
    // dropping the enable pulls the gate low and forgets a pending d1
    n.fge_prev = fast_gate_enable_in;
    if (!fast_gate_enable_in && s.fge_prev) begin
      n.gate_out   = 1'b0;
      n.gate_armed = 1'b0;
    end
    // standby clears both status registers
    if (!s.stby_sync[1]) begin
      n.chan1_status = host_port_pkg::ST_RESET;
      n.chan2_status = host_port_pkg::ST_RESET;
    end
    // reset: control state defined, data buffers left as they are
    if (sys_rst_in) begin
      n = '0;
      n.sel1_sync             = host_port_pkg::SYNC_IDLE;
      n.sel2_sync             = host_port_pkg::SYNC_IDLE;
      n.rd_sync               = host_port_pkg::SYNC_IDLE;
      n.wr_sync               = host_port_pkg::SYNC_IDLE;
      n.stby_sync             = host_port_pkg::SYNC_IDLE;
      n.rd_prev               = 1'b1;
      n.wr_prev               = 1'b1;
      n.host_oe_n             = 1'b1;
      n.gate_out              = host_port_pkg::GATE_RESET;
      n.chan1_status          = host_port_pkg::ST_RESET;
      n.chan2_status          = host_port_pkg::ST_RESET;
      n.chan1_host_in_buffer  = s.chan1_host_in_buffer;
      n.chan1_host_out_buffer = s.chan1_host_out_buffer;
      n.chan2_host_in_buffer  = s.chan2_host_in_buffer;
      n.chan2_host_out_buffer = s.chan2_host_out_buffer;
    end
  end
  always_ff @(posedge clock_in) begin
    s <= n;
  end
  property p_user_stable;
    @(posedge clock_in) disable iff (sys_rst_in)
    !(slave_wr_in && slave_addr_in == host_port_pkg::SLV_CH1_STAT) && s.stby_sync[1]
      |=> $stable(s.chan1_status & host_port_pkg::ST_USER_MASK);
  endproperty
  a_user_stable: assert property (p_user_stable) else $error("user bits changed");
  property p_standby_clear;
    @(posedge clock_in) disable iff (sys_rst_in)
    !s.stby_sync[1] |=> s.chan1_status == host_port_pkg::ST_RESET &&
                        s.chan2_status == host_port_pkg::ST_RESET;
  endproperty
  a_standby_clear: assert property (p_standby_clear) else $error("standby no clear");
  property p_obf_one_ignored;
    @(posedge clock_in) disable iff (sys_rst_in)
    slave_wr_in && slave_addr_in == host_port_pkg::SLV_CH1_STAT &&
      !s.chan1_status[host_port_pkg::ST_OBF_BIT]
      |=> !s.chan1_status[host_port_pkg::ST_OBF_BIT];
  endproperty
  a_obf_one_ignored: assert property (p_obf_one_ignored) else $error("flag set by write");
  property p_obf_zero_clear;
    @(posedge clock_in) disable iff (sys_rst_in)
    slave_wr_in && slave_addr_in == host_port_pkg::SLV_CH1_STAT &&
      !slave_wdata_in[host_port_pkg::ST_OBF_BIT]
      |=> !s.chan1_status[host_port_pkg::ST_OBF_BIT];
  endproperty
  a_obf_zero_clear: assert property (p_obf_zero_clear) else $error("zero did not clear");
  property p_ch1_write;
    @(posedge clock_in) disable iff (sys_rst_in)
    pop && !ev.chan2 && !fast_gate_enable_in && s.stby_sync[1]
      |=> s.chan1_status[host_port_pkg::ST_IBF_BIT] &&
          s.chan1_status[host_port_pkg::ST_CMD_BIT] == $past(ev.addr);
  endproperty
  a_ch1_write: assert property (p_ch1_write) else $error("ch1 write flags");
  property p_ch2_write;
    @(posedge clock_in) disable iff (sys_rst_in)
    pop && ev.chan2 && s.stby_sync[1]
      |=> s.chan2_status[host_port_pkg::ST_IBF_BIT] &&
          s.chan2_host_in_buffer == $past(ev.data) &&
          s.chan2_status[host_port_pkg::ST_CMD_BIT] == $past(ev.addr);
  endproperty
  a_ch2_write: assert property (p_ch2_write) else $error("ch2 write flags");
  property p_ch2_in_read;
    @(posedge clock_in) disable iff (sys_rst_in)
    slave_rd_in && slave_addr_in == host_port_pkg::SLV_CH2_IN
      |=> !s.chan2_status[host_port_pkg::ST_IBF_BIT] &&
          s.slave_rdata == $past(s.chan2_host_in_buffer);
  endproperty
  a_ch2_in_read: assert property (p_ch2_in_read) else $error("ch2 input read");
  property p_ch2_out_write;
    @(posedge clock_in) disable iff (sys_rst_in)
    slave_wr_in && slave_addr_in == host_port_pkg::SLV_CH2_OUT && s.stby_sync[1]
      |=> s.chan2_status[host_port_pkg::ST_OBF_BIT] &&
          s.chan2_host_out_buffer == $past(slave_wdata_in);
  endproperty
  a_ch2_out_write: assert property (p_ch2_out_write) else $error("ch2 output write");
  property p_ch2_host_read;
    @(posedge clock_in) disable iff (sys_rst_in)
    rd_rise && s.rd_tgt2 && !slave_wr_in
      |=> !s.chan2_status[host_port_pkg::ST_OBF_BIT];
  endproperty
  a_ch2_host_read: assert property (p_ch2_host_read) else $error("host read no clear");
  property p_ch2_drive;
    @(posedge clock_in) disable iff (sys_rst_in)
    !s.rd_sync[1] && !sel1 && sel2 && !haddr
      |=> !s.host_oe_n && s.host_dout == $past(s.chan2_host_out_buffer);
  endproperty
  a_ch2_drive: assert property (p_ch2_drive) else $error("ch2 output not driven");
  property p_gate_data;
    @(posedge clock_in) disable iff (sys_rst_in)
    pop && !ev.chan2 && !ev.addr && s.gate_armed && fast_gate_enable_in
      |=> s.gate_out == $past(ev.data[host_port_pkg::GATE_BIT]) ##0
          !s.chan1_status[host_port_pkg::ST_IBF_BIT] [*2];
  endproperty
  a_gate_data: assert property (p_gate_data) else $error("gate data wrong");
endmodule

// ===== dv/host_model.sv
// Purpose: host processor on the 8-bit parallel port
// Assumes: write strobe held low 4 cycles, read strobe 6, both high 4 or more
// Notes:   released bus shows the inverse of the last byte
`timescale 1ns/100ps
module host_model (
  input  wire logic       clock_in,
  input  wire logic [7:0] bus_in,
  input  wire logic       bus_oe_n_in,
  output logic            sel1_n_out,
  output logic            sel2_n_out,
  output logic            rd_n_out,
  output logic            wr_n_out,
  output logic            addr_out,
  output logic      [7:0] bus_out
);
  initial begin
    {sel1_n_out, sel2_n_out, rd_n_out, wr_n_out} = 4'hf;
    addr_out = 1'b0;
    bus_out = 8'h5a;
  end
  // host only writes the input buffers
  task automatic write_cycle(input logic ch2, input logic a, input logic [7:0] d);
    @(posedge clock_in);
    {sel1_n_out, sel2_n_out, addr_out, bus_out} <= {ch2, !ch2, a, d};
    @(posedge clock_in);
    wr_n_out <= 1'b0;
    repeat (4) @(posedge clock_in);
    wr_n_out <= 1'b1;
    @(posedge clock_in);
    {sel1_n_out, sel2_n_out, bus_out} <= {2'b11, ~d}; // stale byte must not look valid
    repeat (4) @(posedge clock_in);
  endtask
  // host only reads status and output buffers
  task automatic read_cycle(input logic ch2, input logic a, output logic [8:0] r);
    @(posedge clock_in);
    {sel1_n_out, sel2_n_out, addr_out} <= {ch2, !ch2, a};
    @(posedge clock_in);
    rd_n_out <= 1'b0;
    repeat (6) @(posedge clock_in);
    r = {bus_oe_n_in, bus_in};
    rd_n_out <= 1'b1;
    @(posedge clock_in);
    {sel1_n_out, sel2_n_out} <= 2'b11;
    repeat (5) @(posedge clock_in);
  endtask
endmodule

// ===== dv/tb_top.sv
// Purpose: self-checking bench for the two-channel host port
// Assumes: slave strobes are one-cycle pulses except a 70-cycle input read, read data one edge later
// Notes:   slave reads queue their expectation; a monitor compares
`timescale 1ns/100ps
module tb_top;
  logic        clock_in, sys_rst_in, hw_standby_n_in, fast_gate_enable_in;
  logic        slave_rd_in, slave_wr_in, rd_seen, ready_dropped;
  logic [2:0]  slave_addr_in;
  logic [7:0]  slave_wdata_in, slave_rdata_out, host_data_in, host_data_out, d, last1;
  logic        sel1_n, sel2_n, rd_n, wr_n, haddr, oe_n, wr_ready, irq1, irq2, gate;
  logic [8:0]  r;
  logic [2:0]  iidx, sidx, oidx;
  logic [31:0] seed;
  logic [7:0]  exp_q[$];
  int          err_count, checks_done, low_run;

  host_port_channel_status_regs u_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .hw_standby_n_in(hw_standby_n_in), .chan1_select_n_in(sel1_n), .chan2_select_n_in(sel2_n),
    .host_read_strobe_n_in(rd_n), .host_write_strobe_n_in(wr_n), .host_addr_bit_in(haddr),
    .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe_n_out(oe_n),
    .host_wr_ready_out(wr_ready), .fast_gate_enable_in(fast_gate_enable_in),
    .slave_addr_in(slave_addr_in), .slave_rd_in(slave_rd_in), .slave_wr_in(slave_wr_in),
    .slave_wdata_in(slave_wdata_in), .slave_rdata_out(slave_rdata_out),
    .chan1_in_full_irq_out(irq1), .chan2_in_full_irq_out(irq2), .gate_a20_out(gate));
  host_model u_host (.clock_in(clock_in), .bus_in(host_data_out), .bus_oe_n_in(oe_n),
    .sel1_n_out(sel1_n), .sel2_n_out(sel2_n), .rd_n_out(rd_n), .wr_n_out(wr_n),
    .addr_out(haddr), .bus_out(host_data_in));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input logic [8:0] seen, input logic [8:0] expd);
    checks_done++;
    if (seen !== expd) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // each slave access spans two edges so a strobe is never driven twice in one step
  task automatic slv(input logic w, input logic [2:0] a, input logic [7:0] v);
    if (!w) exp_q.push_back(v);
    {slave_wr_in, slave_rd_in, slave_addr_in, slave_wdata_in} <= {w, !w, a, v};
    @(posedge clock_in);
    {slave_wr_in, slave_rd_in} <= 2'b00;
    @(posedge clock_in);
  endtask
  task automatic wait_irq(input logic ch2);
    int n;
    for (n = 0; (ch2 ? irq2 : irq1) !== 1'b1; n++) begin
      if (n == 60) begin
        err_count++;
        wrap_up();
      end
      @(posedge clock_in);
    end
  endtask

  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  // read data lands one edge after the pulse; the monitor pops the oldest note then
  always @(posedge clock_in) begin
    if (rd_seen && exp_q.size() > 0) begin
      check({1'b0, slave_rdata_out}, {1'b0, exp_q.pop_front()});
    end
    rd_seen <= slave_rd_in;
    // a lone write holds ready low one cycle; longer means the queue is full
    low_run <= (wr_ready === 1'b0) ? low_run + 1 : 0;
    if (low_run > 1) ready_dropped <= 1'b1;
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    err_count++;
    wrap_up();
  end

  initial begin
    {sys_rst_in, hw_standby_n_in, fast_gate_enable_in, slave_rd_in, slave_wr_in} = 5'b11000;
    {slave_addr_in, slave_wdata_in, rd_seen} = 12'h000;
    seed = 32408;
    repeat (10) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    check(gate, 1);
    slv(0, host_port_pkg::SLV_CH1_STAT, 8'h00);
    slv(0, host_port_pkg::SLV_CH2_STAT, 8'h00);
    slv(1, host_port_pkg::SLV_CH1_STAT, 8'hff);
    slv(0, host_port_pkg::SLV_CH1_STAT, 8'hf4);
    for (int c = 0; c < 2; c++) begin
      {iidx, oidx, sidx} = c ? 9'o345 : 9'o012;
      seed = xs(seed);
      slv(1, sidx, seed[7:0]);
      slv(0, sidx, seed[7:0] & host_port_pkg::ST_USER_MASK);
      slv(1, sidx, 8'h00);
      d = seed[15:8];
      slv(1, oidx, d);
      slv(0, sidx, 8'h01);
      slv(0, oidx, d);
      u_host.read_cycle(c, 1, r);
      check(r, 9'h001);
      u_host.read_cycle(c, 0, r);
      check(r, {1'b0, d});
      slv(0, sidx, 8'h00);
      slv(1, oidx, ~d);
      slv(1, sidx, 8'h01);
      slv(0, sidx, 8'h01);
      slv(1, sidx, 8'h00);
      slv(0, sidx, 8'h00);
      for (int a = 1; a >= 0; a--) begin
        seed = xs(seed);
        d = seed[7:0];
        u_host.write_cycle(c, a, d);
        wait_irq(c);
        slv(0, sidx, {4'h0, a[0], 3'h2});
        slv(1, iidx, ~d);
        slv(0, iidx, d);
        slv(0, sidx, {4'h0, a[0], 3'h0});
        check(c ? irq2 : irq1, 0);
      end
      last1 = c ? last1 : d;
    end
    // drain stalls while the slave keeps reading, so five host writes fill the queue
    ready_dropped = 1'b0;
    fork
      for (int k = 1; k < 6; k++) u_host.write_cycle(1, 0, d + k[7:0]);
      begin
        {slave_addr_in, slave_rd_in} <= {host_port_pkg::SLV_CH1_IN, 1'b1};
        repeat (70) begin
          exp_q.push_back(last1);
          @(posedge clock_in);
        end
        slave_rd_in <= 1'b0;
      end
    join
    @(posedge clock_in);
    check(ready_dropped, 1);
    wait_irq(1);
    repeat (50) @(posedge clock_in);
    slv(0, host_port_pkg::SLV_CH2_IN, d + 8'h05);
    // fast gate: command then data bit 1 drives the gate, no input-full
    fast_gate_enable_in <= 1'b1;
    for (int g = 0; g < 2; g++) begin
      u_host.write_cycle(0, 1, host_port_pkg::CMD_GATE);
      u_host.write_cycle(0, 0, g[0] ? 8'h02 : 8'hfd);
      repeat (8) @(posedge clock_in);
      check({irq1, gate}, {1'b0, g[0]});
    end
    fast_gate_enable_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    check(gate, 0);
    slv(1, host_port_pkg::SLV_CH1_STAT, 8'hf4);
    slv(1, host_port_pkg::SLV_CH2_STAT, 8'hf4);
    hw_standby_n_in <= 1'b0;
    repeat (6) @(posedge clock_in);
    hw_standby_n_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    slv(0, host_port_pkg::SLV_CH1_STAT, 8'h00);
    slv(0, host_port_pkg::SLV_CH2_STAT, 8'h00);
    repeat (3) @(posedge clock_in);
    wrap_up();
  end
endmodule
